// file: iecp_parser.sv
// Top: escape detection and command line collection on the terminal port
`timescale 1ns/1ps
module iecp_parser #(
  parameter int unsigned LINE_DEPTH = iecp_pkg::LINE_MAX,
  parameter int unsigned TICK_CYC   = iecp_pkg::GUARD_TICK_CYC
) (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rst_b,
  // Terminal port characters
  input  wire logic                    rxValid,
  input  wire logic [7:0]              rxChar,
  // Forward path to network
  output      logic                    netValid,
  output      logic [7:0]              netChar,
  // Command line hand-off
  output      logic                    lineExec,
  output      logic [7:0]              lineLen,
  output      logic [8*LINE_DEPTH-1:0] lineData,
  output      logic                    okResp,
  output      logic                    cmdMode,
  // Command side control
  input  wire logic                    cmdDone,
  input  wire logic                    loadReq,
  input  wire logic [1:0]              loadSel,
  input  wire logic                    wrGuard,
  input  wire logic                    wrTerm,
  input  wire logic [7:0]              wrData,
  // Non-volatile image
  input  wire iecp_pkg::iecp_profile_t nvImage,
  output      iecp_pkg::iecp_profile_t nvStore,
  output      logic                    nvWrite,
  output      logic [7:0]              guardTime,
  output      logic [7:0]              termChar
);
  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rstMeta, rstSyncB;                         // Two-stage release
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta  <= 1'b0;
      rstSyncB <= 1'b0;
    end else begin
      rstMeta  <= 1'b1;
      rstSyncB <= rstMeta;
    end
  end

  // ----------------------------------------------------------------
  // Profile store
  // ----------------------------------------------------------------
  iecp_pkg::iecp_profile_t active;                 // Settings in use
  logic                    nvWriteInt;             // Store strobe
  iecp_pkg::iecp_profile_t nvStoreInt;             // Store image
  iecp_profile_store uStore (
    .core_clk (core_clk),
    .rstSyncB (rstSyncB),
    .loadReq  (loadReq),
    .loadSel  (loadSel),
    .wrGuard  (wrGuard),
    .wrTerm   (wrTerm),
    .wrData   (wrData),
    .nvImage  (nvImage),
    .nvStore  (nvStoreInt),
    .nvWrite  (nvWriteInt),
    .active   (active)
  );

  // ----------------------------------------------------------------
  // Guard tick divider and silence counter
  // ----------------------------------------------------------------
  logic [31:0] divReg, divNext;                    // Cycle divider
  logic        tick;                               // One pulse per guard unit
  logic [7:0]  quietReg, quietNext;                // Ticks since last character
  assign tick = (divReg == TICK_CYC - 1);
  always_comb begin
    divNext   = tick ? 32'h0000_0000 : divReg + 32'h0000_0001;
    quietNext = quietReg;
    if (rxValid) quietNext = 8'h00;
    else if (tick && quietReg != 8'hFF) quietNext = quietReg + 8'h01;
  end
  always_ff @(posedge core_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      divReg   <= 32'h0000_0000;
      quietReg <= 8'hFF;
    end else begin
      divReg   <= divNext;
      quietReg <= quietNext;
    end
  end
  logic guardMet;                                  // Silence of full guard time
  assign guardMet = (quietReg >= active.guardTime);

  // ----------------------------------------------------------------
  // Parser state
  // ----------------------------------------------------------------
  iecp_pkg::iecp_state_t   stReg, stNext;          // Mode and prefix state
  logic [1:0]              escReg, escNext;        // Escapes seen in a row
  logic                    preQuietReg, preQuietNext; // Guard held before first escape
  logic [7:0]              lenReg, lenNext;        // Buffered characters
  logic [7:0]              buf_q [LINE_DEPTH];     // Line buffer
  logic                    bufWr;                  // Write strobe
  logic [7:0]              bufIdx;                 // Write slot
  logic                    netVReg, netVNext;
  logic [7:0]              netCReg, netCNext;
  logic                    execReg, execNext;
  logic                    okReg, okNext;
  logic [7:0]              upper;                  // Case-folded input
  assign upper = rxChar & ~iecp_pkg::CASE_BIT;
  // Only letters are folded: digits and punctuation must reach the decoder unchanged
  logic                    isLower;                // Lower-case letter on the port
  logic [7:0]              folded;                 // Buffered form of the character
  assign isLower = ((rxChar & iecp_pkg::CASE_BIT) != 8'h00) && (upper >= iecp_pkg::CHR_A)
                   && (upper <= iecp_pkg::CHR_A + 8'h19);
  assign folded  = isLower ? upper : rxChar;

  // Next-state logic for the character stream
  always_comb begin
    stNext       = stReg;
    escNext      = escReg;
    preQuietNext = preQuietReg;
    lenNext      = lenReg;
    netVNext     = 1'b0;
    netCNext     = netCReg;
    execNext     = 1'b0;
    okNext       = 1'b0;
    bufWr        = 1'b0;
    bufIdx       = lenReg;
    case (stReg)
      iecp_pkg::ST_DATA: begin
        if (rxValid) begin
          netVNext = 1'b1;
          netCNext = rxChar;
          if (rxChar == active.escChar) begin
            if (escReg == 2'h0) begin
              preQuietNext = guardMet;
              escNext      = 2'h1;
            end else if (!guardMet) begin
              escNext = escReg + 2'h1;
            end else begin
              preQuietNext = 1'b1;
              escNext      = 2'h1;
            end
            if (escReg == 2'(iecp_pkg::ESC_COUNT - 1) && !guardMet && preQuietReg) begin
              stNext   = iecp_pkg::ST_PRE1;
              netVNext = 1'b0;
              escNext  = 2'h0;
            end
          end else begin
            escNext = 2'h0;
          end
        end
      end
      iecp_pkg::ST_PRE1: begin
        if (rxValid && upper == iecp_pkg::CHR_A) stNext = iecp_pkg::ST_PRE2;
      end
      iecp_pkg::ST_PRE2: begin
        if (rxValid) begin
          if (upper == iecp_pkg::CHR_T) begin
            stNext  = iecp_pkg::ST_BODY;
            lenNext = 8'h00;
          end else if (upper != iecp_pkg::CHR_A) begin
            stNext = iecp_pkg::ST_PRE1;
          end
        end
      end
      iecp_pkg::ST_BODY: begin
        if (rxValid) begin
          if (rxChar == iecp_pkg::CHR_CAN) begin
            okNext  = 1'b1;
            lenNext = 8'h00;
            stNext  = iecp_pkg::ST_PRE1;
          end else if (rxChar == active.termChar) begin
            execNext = 1'b1;
            stNext   = iecp_pkg::ST_PRE1;
          end else if (rxChar == iecp_pkg::CHR_BS) begin
            if (lenReg != 8'h00) lenNext = lenReg - 8'h01;
          end else if (rxChar == iecp_pkg::CHR_SPACE) begin
            lenNext = lenReg;
          end else if (lenReg < 8'(LINE_DEPTH)) begin
            bufWr   = 1'b1;
            lenNext = lenReg + 8'h01;
          end
        end
      end
      default: stNext = iecp_pkg::ST_DATA;
    endcase
    if (cmdDone) stNext = iecp_pkg::ST_DATA;
  end

  // State registers
  always_ff @(posedge core_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      stReg       <= iecp_pkg::ST_DATA;
      escReg      <= 2'h0;
      preQuietReg <= 1'b0;
      lenReg      <= 8'h00;
      netVReg     <= 1'b0;
      netCReg     <= 8'h00;
      execReg     <= 1'b0;
      okReg       <= 1'b0;
    end else begin
      stReg       <= stNext;
      escReg      <= escNext;
      preQuietReg <= preQuietNext;
      lenReg      <= lenNext;
      netVReg     <= netVNext;
      netCReg     <= netCNext;
      execReg     <= execNext;
      okReg       <= okNext;
    end
  end

  // Line buffer, one slot per character
  genvar g;
  generate
    for (g = 0; g < LINE_DEPTH; g++) begin : gSlot
      always_ff @(posedge core_clk or negedge rstSyncB) begin
        if (!rstSyncB) buf_q[g] <= 8'h00;
        else if (bufWr && bufIdx == 8'(g)) buf_q[g] <= folded;
      end
      assign lineData[8*g +: 8] = buf_q[g];
    end
  endgenerate

  // Registered outputs
  logic       cmdModeReg;
  logic [7:0] lenOutReg;
  always_ff @(posedge core_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      cmdModeReg <= 1'b0;
      lenOutReg  <= 8'h00;
    end else begin
      cmdModeReg <= (stNext != iecp_pkg::ST_DATA);
      lenOutReg  <= lenNext;
    end
  end

  assign netValid  = netVReg;
  assign netChar   = netCReg;
  assign lineExec  = execReg;
  assign lineLen   = lenOutReg;
  assign okResp    = okReg;
  assign cmdMode   = cmdModeReg;
  assign nvStore   = nvStoreInt;
  assign nvWrite   = nvWriteInt;
  assign guardTime = active.guardTime;
  assign termChar  = active.termChar;
endmodule

// file: iecp_pkg.sv
// Shared constants and carrier types for the in-band escape command parser
// What this block does
// - Stored profile reapplied after every power-on reset
// - Four fixed profiles, profile one default
// - Escape and commands only from terminal port
// - Silence of guard time before first escape
// - Guard time programmable, defaults to one second
// - Three escapes, each gap under guard time
// - Line starts with attention prefix, any case
// - Cancel after prefix discards line, answers OK
// - Several commands per line, spaces dropped
// - Line buffer holds at least forty characters
// - Terminator executes line, default carriage return
// - Backspace removes last buffered character
package iecp_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 50000000;
  localparam int unsigned GUARD_TICK_MS  = 20;      // Guard setting unit in ms
  localparam int unsigned GUARD_TICK_CYC = CLK_HZ / 1000 * GUARD_TICK_MS;
  // ----------------------------------------------------------------
  // Characters and defaults
  // ----------------------------------------------------------------
  localparam logic [7:0] CHR_CR     = 8'h0D;
  localparam logic [7:0] CHR_BS     = 8'h08;
  localparam logic [7:0] CHR_CAN    = 8'h18;
  localparam logic [7:0] CHR_SPACE  = 8'h20;
  localparam logic [7:0] CHR_ESC    = 8'h2B;
  localparam logic [7:0] CHR_A      = 8'h41;
  localparam logic [7:0] CHR_T      = 8'h54;
  localparam logic [7:0] CASE_BIT   = 8'h20;
  localparam logic [7:0] GUARD_DEF  = 8'h32;        // 50 ticks of 20 ms: one second
  localparam int unsigned LINE_MAX  = 40;
  localparam int unsigned PROF_CNT  = 4;
  localparam logic [1:0] PROF_DEF   = 2'h0;         // Profile number 1
  localparam int unsigned ESC_COUNT = 3;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] guardTime;
    logic [7:0] termChar;
    logic [7:0] escChar;
    logic [7:0] options;
  } iecp_profile_t;
  typedef enum logic [3:0] {
    ST_DATA = 4'h1,
    ST_PRE1 = 4'h2,
    ST_PRE2 = 4'h4,
    ST_BODY = 4'h8
  } iecp_state_t;
endpackage

// file: iecp_profile_store.sv
// Profile store: four fixed profiles plus the non-volatile active copy
`timescale 1ns/1ps
module iecp_profile_store (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rstSyncB,
  // Control
  input  wire logic                   loadReq,
  input  wire logic [1:0]             loadSel,
  input  wire logic                   wrGuard,
  input  wire logic                   wrTerm,
  input  wire logic [7:0]             wrData,
  // Non-volatile image
  input  wire iecp_pkg::iecp_profile_t nvImage,
  output      iecp_pkg::iecp_profile_t nvStore,
  output      logic                   nvWrite,
  // Active set
  output      iecp_pkg::iecp_profile_t active
);
  // ----------------------------------------------------------------
  // Fixed read-only profiles
  // ----------------------------------------------------------------
  function automatic iecp_pkg::iecp_profile_t romProfile(input logic [1:0] idx);
    iecp_pkg::iecp_profile_t p;
    p = '{iecp_pkg::GUARD_DEF, iecp_pkg::CHR_CR, iecp_pkg::CHR_ESC, {6'h00, idx}};
    return p;
  endfunction

  iecp_pkg::iecp_profile_t activeReg, activeNext;   // Active profile
  logic                    loadedReg, loadedNext;   // Image taken after reset
  logic                    nvWrReg,   nvWrNext;     // Store strobe

  // Next-state: reload at reset release, then loads and edits
  always_comb begin
    activeNext = activeReg;
    loadedNext = 1'b1;
    nvWrNext   = 1'b0;
    if (!loadedReg) begin
      activeNext = nvImage;
    end else if (loadReq) begin
      activeNext = romProfile(loadSel);
      nvWrNext   = 1'b1;
    end else if (wrGuard || wrTerm) begin
      if (wrGuard) activeNext.guardTime = wrData;
      if (wrTerm)  activeNext.termChar  = wrData;
      nvWrNext = 1'b1;
    end
  end

  // Registers
  always_ff @(posedge core_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      // Profile one until the stored image is read
      activeReg <= '{iecp_pkg::GUARD_DEF, iecp_pkg::CHR_CR, iecp_pkg::CHR_ESC,
                     {6'h00, iecp_pkg::PROF_DEF}};
      loadedReg <= 1'b0;
      nvWrReg   <= 1'b0;
    end else begin
      activeReg <= activeNext;
      loadedReg <= loadedNext;
      nvWrReg   <= nvWrNext;
    end
  end

  assign active  = activeReg;
  assign nvStore = activeReg;
  assign nvWrite = nvWrReg;
endmodule

// file: iecp_parser_checker.sv
// Checker: port-level properties of the escape command parser
`timescale 1ns/1ps
module iecp_parser_checker #(
  parameter int unsigned LINE_DEPTH = iecp_pkg::LINE_MAX
) (
  // Clock and reset
  input wire logic                    core_clk,
  input wire logic                    rst_b,
  // Terminal characters
  input wire logic                    rxValid,
  input wire logic [7:0]              rxChar,
  // Parser outputs
  input wire logic                    netValid,
  input wire logic [7:0]              netChar,
  input wire logic                    lineExec,
  input wire logic [7:0]              lineLen,
  input wire logic                    okResp,
  input wire logic                    cmdMode,
  // Control and settings
  input wire logic                    cmdDone,
  input wire logic                    loadReq,
  input wire logic                    wrGuard,
  input wire logic [7:0]              wrData,
  input wire iecp_pkg::iecp_profile_t nvImage,
  input wire logic [7:0]              guardTime,
  input wire logic [7:0]              termChar
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  // A plain data character taken in data mode
  sequence s_dataChar;
    rxValid && !cmdMode && !cmdDone && rxChar != nvImage.escChar;
  endsequence
  // The same character handed on one cycle later
  sequence s_fwd;
    netValid && netChar == $past(rxChar);
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  AST_FWD: assert property (s_dataChar |=> s_fwd)
    else $error("data char not forwarded");
  AST_ESC_ENTRY: assert property ($rose(cmdMode) |->
    $past(rxValid) && $past(rxChar) == nvImage.escChar)
    else $error("command mode entered without escape char");
  AST_NO_FWD_CMD: assert property (cmdMode && $past(cmdMode) |-> !netValid)
    else $error("char forwarded in command mode");
  AST_EXEC: assert property (lineExec |->
    $past(rxValid) && $past(rxChar) == $past(termChar))
    else $error("line executed without terminator");
  AST_CANCEL: assert property (okResp |->
    $past(rxValid) && $past(rxChar) == iecp_pkg::CHR_CAN)
    else $error("OK without cancel char");
  AST_LEN_MAX: assert property (lineLen <= LINE_DEPTH)
    else $error("line length above limit");
  AST_BS: assert property (cmdMode && rxValid && rxChar == iecp_pkg::CHR_BS |=>
    lineLen <= $past(lineLen))
    else $error("backspace grew the line");
  AST_SPACE: assert property (cmdMode && rxValid && rxChar == iecp_pkg::CHR_SPACE |=>
    $stable(lineLen))
    else $error("space was buffered");
  AST_NV_LOAD: assert property ($rose(rst_b) |-> ##[2:5] (guardTime == nvImage.guardTime))
    else $error("stored profile not applied");
  AST_WR_GUARD: assert property (wrGuard |=> guardTime == $past(wrData))
    else $error("guard write lost");
  AST_LOAD: assert property (loadReq |-> ##[1:2]
    (guardTime == iecp_pkg::GUARD_DEF && termChar == iecp_pkg::CHR_CR))
    else $error("fixed profile settings wrong");
endmodule
bind iecp_parser iecp_parser_checker #(.LINE_DEPTH(LINE_DEPTH)) u_iecp_parser_checker (
  .core_clk(core_clk), .rst_b(rst_b), .rxValid(rxValid), .rxChar(rxChar),
  .netValid(netValid), .netChar(netChar), .lineExec(lineExec), .lineLen(lineLen),
  .okResp(okResp), .cmdMode(cmdMode), .cmdDone(cmdDone), .loadReq(loadReq),
  .wrGuard(wrGuard), .wrData(wrData), .nvImage(nvImage), .guardTime(guardTime),
  .termChar(termChar));

// file: iecp_term_model.sv
// Terminal model: sends characters on the asynchronous port
`timescale 1ns/1ps
module iecp_term_model (
  // Clock
  input  wire logic       core_clk,
  // Character strobe toward the parser
  output      logic       rxValid,
  output      logic [7:0] rxChar
);
  // Idle line at time zero
  initial begin
    rxValid = 1'b0;
    rxChar  = 8'hA5;
  end
  // One character, then gap idle cycles; callers set quiet spans and escape gaps
  task automatic sendChar(input logic [7:0] c, input int gap);
    @(posedge core_clk);
    rxValid <= 1'b1;
    rxChar  <= c;
    @(posedge core_clk);
    rxValid <= 1'b0;
    rxChar  <= ~c;  // No stale character left on the idle line
    repeat (gap) @(posedge core_clk);
  endtask
endmodule

// file: test_iecp_parser.sv
// Testbench for the in-band escape command parser
`timescale 1ns/1ps
module test_iecp_parser;
  localparam int unsigned DEPTH = 40;
  logic                    core_clk = 1'b0;
  logic                    rst_b = 1'b0;
  logic                    rxValid, netValid, lineExec, okResp, cmdMode, nvWrite;
  logic [7:0]              rxChar, netChar, lineLen, guardTime, termChar;
  logic [8*DEPTH-1:0]      lineData;
  logic                    cmdDone = 1'b0, loadReq = 1'b0, wrGuard = 1'b0, wrTerm = 1'b0;
  logic [7:0]              wrData = 8'h00;
  logic [1:0]              loadSel = 2'h0;
  iecp_pkg::iecp_profile_t nvImage = '{8'h06, 8'h0D, 8'h2B, 8'h00};
  iecp_pkg::iecp_profile_t nvStore;
  int                      mismatches = 0, num_checks = 0, execCnt = 0, okCnt = 0;
  int                      nvWrCnt = 0;  // Store strobes seen
  logic [31:0]             seed = 32'h00015E76;
  logic [7:0]              fwdQ[$];  // Characters expected on the network side
  always #10 core_clk = ~core_clk;
  iecp_term_model u_iecp_term_model (.core_clk(core_clk), .rxValid(rxValid), .rxChar(rxChar));
  iecp_parser #(.LINE_DEPTH(DEPTH), .TICK_CYC(10)) u_iecp_parser (
    .core_clk(core_clk), .rst_b(rst_b), .rxValid(rxValid), .rxChar(rxChar),
    .netValid(netValid), .netChar(netChar), .lineExec(lineExec), .lineLen(lineLen),
    .lineData(lineData), .okResp(okResp), .cmdMode(cmdMode), .cmdDone(cmdDone),
    .loadReq(loadReq), .loadSel(loadSel), .wrGuard(wrGuard), .wrTerm(wrTerm),
    .wrData(wrData), .nvImage(nvImage), .nvStore(nvStore), .nvWrite(nvWrite),
    .guardTime(guardTime), .termChar(termChar));
  // Xorshift source
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Expected buffered form of a character
  function automatic logic [7:0] fold(input logic [7:0] c);
    return (c >= 8'h61 && c <= 8'h7A) ? (c & ~iecp_pkg::CASE_BIT) : c;
  endfunction
  task automatic check(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic send(input logic [7:0] c, input int gap, input bit fwd);
    if (fwd) fwdQ.push_back(c);
    u_iecp_term_model.sendChar(c, gap);
  endtask
  task automatic sendStr(input string s);
    foreach (s[i]) send(s[i], 1, 1'b0);
    repeat (3) @(posedge core_clk);
  endtask
  // One control pulse: 0 guard write, 1 terminator write, 2 profile load, 3 done
  task automatic pulse(input int which, input logic [7:0] d);
    @(posedge core_clk);
    wrData  <= d;
    loadSel <= d[1:0];
    wrGuard <= (which == 0);
    wrTerm  <= (which == 1);
    loadReq <= (which == 2);
    cmdDone <= (which == 3);
    @(posedge core_clk);
    {wrGuard, wrTerm, loadReq, cmdDone} <= 4'h0;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Network side monitor and pulse counters
  always @(posedge core_clk) begin
    if (netValid === 1'b1) begin
      if (fwdQ.size() == 0) check(1'b0, "unexpected forward");
      else check(netChar === fwdQ.pop_front(), "forwarded char");
    end
    if (lineExec === 1'b1) execCnt++;
    if (okResp === 1'b1) okCnt++;
    if (nvWrite === 1'b1) nvWrCnt++;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    close_out();
  end
  initial begin
    logic [31:0] r;
    logic [7:0]  c;
    int          n;
    int          k;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge core_clk);
    check(guardTime === 8'h06 && termChar === 8'h0D, "stored profile");
    pulse(0, 8'h04);
    check(guardTime === 8'h04, "guard write");
    check(nvWrCnt === 1 && nvStore.guardTime === 8'h04, "guard stored");
    repeat (20) begin
      r = xs();
      c = (r[7:0] == 8'h2B) ? 8'h2C : r[7:0];
      send(c, int'(r[9:8]), 1'b1);
    end
    send(8'h2B, 2, 1'b1);
    send(8'h2B, 2, 1'b1);
    send(8'h2B, 4, 1'b1);
    check(cmdMode === 1'b0, "escape without silence");
    repeat (80) @(posedge core_clk);
    send(8'h2B, 80, 1'b1);
    send(8'h2B, 2, 1'b1);
    send(8'h2B, 4, 1'b1);
    check(cmdMode === 1'b0, "escape with long gap");
    $display("test data and refused escapes done");
    repeat (80) @(posedge core_clk);
    send(8'h2B, 1, 1'b1);
    send(8'h2B, 1, 1'b1);
    send(8'h2B, 3, 1'b0);
    check(cmdMode === 1'b1, "valid escape");
    send(8'h78, 2, 1'b0);
    n = execCnt;
    sendStr("aTxq\010 1\015");
    check(execCnt === n + 1, "line executed");
    check(lineLen === 8'd2 && lineData[15:0] === {fold(8'h31), fold(8'h78)}, "line");
    n = okCnt;
    k = execCnt;
    sendStr("Atk\030");
    check(okCnt === n + 1 && execCnt === k, "cancel");
    $display("test command lines done");
    sendStr("AT");
    repeat (45) begin
      r = xs();
      send(8'h61 + 8'(r % 32'd26), 0, 1'b0);
    end
    repeat (3) @(posedge core_clk);
    check(lineLen === 8'd40, "line limit");
    sendStr("\015");
    pulse(1, 8'h21);
    check(termChar === 8'h21, "terminator write");
    n = execCnt;
    sendStr("atz!");
    check(execCnt === n + 1 && lineLen === 8'd1 && lineData[7:0] === fold(8'h7A), "new term");
    pulse(3, 8'h00);
    check(cmdMode === 1'b0, "back to data");
    send(8'h51, 3, 1'b1);
    $display("test limit and terminator done");
    for (int s = 0; s < 4; s++) begin
      pulse(2, 8'(s));
      check(guardTime === iecp_pkg::GUARD_DEF && termChar === iecp_pkg::CHR_CR, "fixed profile");
    end
    repeat (4) @(posedge core_clk);
    check(fwdQ.size() == 0, "chars lost");
    check(nvWrCnt === 6, "store strobes");
    $display("test profiles done");
    close_out();
  end
endmodule
